// ---- rtl/svctl_pkg.sv ----
package svctl_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int MON_W   = 12;
    localparam int NSEL    = 3;
    // ------------------------------------------------------------
    // thresholds, in percent of the target level
    // ------------------------------------------------------------
    localparam int OVP_PCT      = 110;
    localparam int DSCHG_PCT    = 110;
    localparam int PCT_DIV      = 100;
    // bus valid window, in monitor codes after the external divider
    localparam logic [11:0] VALID_LO  = 12'h0E6;
    localparam logic [11:0] VALID_HI  = 12'h70A;
    // ------------------------------------------------------------
    // synchroniser and filter
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam int CLK_MHZ     = 50;
    localparam int FILT_US     = 1;
    localparam int FILT_CYC    = CLK_MHZ * FILT_US;
    localparam logic [1:0] SEL_NONE = 2'h3;

    typedef struct packed {
        logic       sel_ena;
        logic       bpres_ena;
        logic       chg_ena;
    } svctl_prof_t;

    typedef struct packed {
        logic       ufp;
        logic       micro_a;
        logic       contract;
        logic       transition;
    } svctl_stat_t;

    typedef enum logic [1:0] {
        SVCTL_IDLE  = 2'h0,
        SVCTL_DSCHG = 2'h1,
        SVCTL_HOLD  = 2'h3
    } svctl_st_t;
endpackage

// ---- rtl/svctl_sync.sv ----
`timescale 1ns/100ps
module svctl_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    wire  [W-1:0] nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;

    // ------------------------------------------------------------
    // three stages, change counted when stage 2 and 3 agree
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_ff  <= '0;
        end else begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end
    assign q_o = q_ff;
endmodule

// ---- rtl/svctl_top.sv ----
`timescale 1ns/100ps
module svctl_top
    import svctl_pkg::*;
#(
    parameter int NSUP = 3
) (
    input  wire logic                       mclk_i,
    input  wire logic                       rstn_i,
    input  wire logic [svctl_pkg::MON_W-1:0] bus_voltage_monitor_i,
    input  wire logic [svctl_pkg::MON_W-1:0] level_tab_i [svctl_pkg::NSEL],
    input  wire logic [1:0]                 sel_idx_i,
    input  wire logic                       sel_req_i,
    input  wire logic                       dsc_req_i,
    input  wire svctl_pkg::svctl_prof_t     prof_i,
    input  wire svctl_pkg::svctl_stat_t     stat_i,
    input  wire logic                       micro_a_pin_i,
    output logic [svctl_pkg::NSEL-1:0]      src_volt_sel_n_o,
    output logic [svctl_pkg::NSEL-1:0]      src_volt_sel_oe_o,
    output logic                            overvoltage_protect_o,
    output logic                            fault_n_o,
    output logic                            fault_n_oe_o,
    output logic                            bus_discharge_drive_o,
    output logic                            bus_present_out_o,
    output logic                            receptacle_id_indicator_o,
    output logic                            charger_emulation_enable_o
);
    import svctl_pkg::*;

    // elaboration check: the select field cannot serve more than NSEL
    if (NSUP < 1 || NSUP > NSEL) begin : g_nsup_bad
        $error("NSUP out of range");
    end

    // ------------------------------------------------------------
    // pin input synchronisation
    // ------------------------------------------------------------
    logic micro_a_s;
    svctl_sync #(.W(1)) u_sync (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .d_i    (micro_a_pin_i),
        .q_o    (micro_a_s)
    );

    // ------------------------------------------------------------
    // threshold arithmetic
    // ------------------------------------------------------------
    function automatic logic [MON_W+7:0] scale(
        input logic [MON_W-1:0] v,
        input int               pct
    );
        scale = (MON_W+8)'(int'(v) * pct / PCT_DIV);
    endfunction

    wire        sel_ok  = sel_req_i && (int'(sel_idx_i) < NSUP);
    wire [MON_W-1:0] sel_lvl = level_tab_i[sel_idx_i < 2'h3 ? sel_idx_i
                                                           : 2'h0];
    // monitor is compared in divided units; table shares the divider
    wire [MON_W+7:0] mon_w  = {8'h00, bus_voltage_monitor_i};
    wire ovp_hit = sel_ok && (mon_w > scale(sel_lvl, OVP_PCT));
    wire dsc_done = (mon_w <= scale(sel_lvl, DSCHG_PCT));
    wire bus_valid = (bus_voltage_monitor_i >= VALID_LO) &&
                     (bus_voltage_monitor_i <= VALID_HI);

    // ------------------------------------------------------------
    // discharge sequencer
    // ------------------------------------------------------------
    svctl_st_t st_ff;
    svctl_st_t nxt_st;
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            SVCTL_IDLE: begin
                if (dsc_req_i && !dsc_done) begin
                    nxt_st = SVCTL_DSCHG;
                end
            end
            SVCTL_DSCHG: begin
                // a withdrawn transition must not leave the fet on
                if (!dsc_req_i) begin
                    nxt_st = SVCTL_IDLE;
                end else if (dsc_done) begin
                    nxt_st = SVCTL_HOLD;
                end
            end
            SVCTL_HOLD: begin
                if (!dsc_req_i) begin
                    nxt_st = SVCTL_IDLE;
                end
            end
            default: nxt_st = SVCTL_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // output decode
    // ------------------------------------------------------------
    // one-hot of the selected index; drives nothing without a request
    wire [NSEL-1:0] nxt_oe = (sel_ok && prof_i.sel_ena) ?
                             NSEL'(1 << sel_idx_i) : '0;
    // presence held while a transition is running
    wire nxt_bpres = prof_i.bpres_ena && stat_i.ufp &&
                     (bus_valid || stat_i.transition);
    wire nxt_chg = prof_i.chg_ena && !stat_i.contract &&
                   bus_valid;
    wire nxt_id = !(micro_a_s || stat_i.micro_a);

    logic [NSEL-1:0] oe_ff;
    logic            ovp_ff;
    logic            dsc_ff;
    logic            bpres_ff;
    logic            id_ff;
    logic            chg_ff;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff    <= SVCTL_IDLE;
            oe_ff    <= '0;
            ovp_ff   <= 1'b0;
            dsc_ff   <= 1'b0;
            bpres_ff <= 1'b0;
            id_ff    <= 1'b1;
            chg_ff   <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            oe_ff    <= nxt_oe;
            ovp_ff   <= ovp_hit;
            dsc_ff   <= (nxt_st == SVCTL_DSCHG);
            bpres_ff <= nxt_bpres;
            id_ff    <= nxt_id;
            chg_ff   <= nxt_chg;
        end
    end

    assign src_volt_sel_n_o           = '0;
    assign src_volt_sel_oe_o          = oe_ff;
    assign overvoltage_protect_o      = ovp_ff;
    assign fault_n_o                  = 1'b0;
    assign fault_n_oe_o               = ovp_ff;
    assign bus_discharge_drive_o      = dsc_ff;
    assign bus_present_out_o          = bpres_ff;
    assign receptacle_id_indicator_o  = id_ff;
    assign charger_emulation_enable_o = chg_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_onehot;
        @(posedge mclk_i) disable iff (!rstn_i)
        $onehot0(src_volt_sel_oe_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two selects");

    property p_sel;
        @(posedge mclk_i) disable iff (!rstn_i)
        (sel_req_i && prof_i.sel_ena && sel_idx_i == 2'h0) |=>
            src_volt_sel_oe_o[0];
    endproperty
    a_sel: assert property (p_sel) else $error("select missing");

    property p_rsv;
        @(posedge mclk_i) disable iff (!rstn_i)
        (int'(sel_idx_i) >= NSUP) |=> src_volt_sel_oe_o == '0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved driven");

    property p_ovp;
        @(posedge mclk_i) disable iff (!rstn_i)
        (sel_req_i && int'(sel_idx_i) < NSUP &&
         int'(bus_voltage_monitor_i) * PCT_DIV > int'(sel_lvl) * OVP_PCT)
            |=> (overvoltage_protect_o && fault_n_oe_o);
    endproperty
    a_ovp: assert property (p_ovp) else $error("ovp not flagged");

    property p_dsc_end;
        @(posedge mclk_i) disable iff (!rstn_i)
        (bus_discharge_drive_o && dsc_done) |=> !bus_discharge_drive_o;
    endproperty
    a_dsc_end: assert property (p_dsc_end) else $error("dsc stuck");

    property p_dsc_go;
        @(posedge mclk_i) disable iff (!rstn_i)
        (st_ff == SVCTL_IDLE && dsc_req_i && !dsc_done) |=>
            bus_discharge_drive_o;
    endproperty
    a_dsc_go: assert property (p_dsc_go) else $error("no dsc");

    property p_bpres;
        @(posedge mclk_i) disable iff (!rstn_i)
        (prof_i.bpres_ena && stat_i.ufp && stat_i.transition) |=>
            bus_present_out_o;
    endproperty
    a_bpres: assert property (p_bpres) else $error("presence lost");

    property p_chg;
        @(posedge mclk_i) disable iff (!rstn_i)
        stat_i.contract |=> !charger_emulation_enable_o;
    endproperty
    a_chg: assert property (p_chg) else $error("emulation on");

    property p_prof;
        @(posedge mclk_i) disable iff (!rstn_i)
        !prof_i.chg_ena |=> !charger_emulation_enable_o;
    endproperty
    a_prof: assert property (p_prof) else $error("profile leak");

    c_sel2: cover property (@(posedge mclk_i) src_volt_sel_oe_o[2]);
    c_dsc:  cover property (@(posedge mclk_i)
                bus_discharge_drive_o ##1 !bus_discharge_drive_o);
    c_ovp:  cover property (@(posedge mclk_i) overvoltage_protect_o);
endmodule

// ---- sim/svctl_conv_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// converter, discharge fet and divider
// ----------------------------------------
module svctl_conv_model
    import svctl_pkg::*;
(
    input  wire logic                        mclk_i,
    input  wire logic [svctl_pkg::NSEL-1:0]  sel_pin_i,
    input  wire logic [svctl_pkg::MON_W-1:0] lvl_i [svctl_pkg::NSEL],
    input  wire logic                        dsch_i,
    input  wire logic                        frc_i,
    input  wire logic [svctl_pkg::MON_W-1:0] frc_val_i,
    output logic      [svctl_pkg::MON_W-1:0] mon_o
);
    import svctl_pkg::*;
    logic [MON_W-1:0] tgt;
    logic [MON_W-1:0] v_ff = 12'h000;
    // no select pulled low: output decays toward zero
    always_comb begin
        tgt = 12'h000;
        for (int i = 0; i < NSEL; i++) begin
            if (!sel_pin_i[i]) begin
                tgt = lvl_i[i];
            end
        end
    end
    // slow ramp; only the fet pulls the bus down fast
    always @(posedge mclk_i) begin
        if (dsch_i && v_ff > 12'h010) begin
            v_ff <= v_ff - 12'h010;
        end else if (v_ff < tgt) begin
            v_ff <= v_ff + 12'h004;
        end else if (v_ff > tgt) begin
            v_ff <= v_ff - 12'h001;
        end
    end
    assign mon_o = frc_i ? frc_val_i : v_ff;
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import svctl_pkg::*;
    localparam int NS = 2;
    logic             mclk_i = 1'b0;
    logic             rstn_i = 1'b0;
    logic [MON_W-1:0] mon;
    logic [MON_W-1:0] lvl [NSEL];
    logic [1:0]       idx = 2'h0;
    logic             req = 1'b0;
    logic             dsc = 1'b0;
    svctl_prof_t      prof = '0;
    svctl_stat_t      stat = '0;
    logic             pin = 1'b0;
    logic             frc = 1'b1;
    logic [MON_W-1:0] fval = 12'h000;
    logic [NSEL-1:0]  sel_n, sel_oe;
    logic             overvoltage_protect, flt_n, flt_oe, dsch, bpres, rid, chg;
    int               err_count = 0;
    int               check_count = 0;
    assign lvl = '{12'h199, 12'h3D6, 12'h666};
    svctl_top #(.NSUP(NS)) svctl_top_i (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .bus_voltage_monitor_i(mon),
        .level_tab_i(lvl), .sel_idx_i(idx), .sel_req_i(req),
        .dsc_req_i(dsc), .prof_i(prof), .stat_i(stat),
        .micro_a_pin_i(pin), .src_volt_sel_n_o(sel_n),
        .src_volt_sel_oe_o(sel_oe), .overvoltage_protect_o(overvoltage_protect),
        .fault_n_o(flt_n), .fault_n_oe_o(flt_oe),
        .bus_discharge_drive_o(dsch), .bus_present_out_o(bpres),
        .receptacle_id_indicator_o(rid),
        .charger_emulation_enable_o(chg));
    // open drain select lines are pulled up when released
    svctl_conv_model svctl_conv_model_i (
        .mclk_i(mclk_i), .sel_pin_i(~sel_oe | sel_n), .lvl_i(lvl),
        .dsch_i(dsch), .frc_i(frc), .frc_val_i(fval), .mon_o(mon));
    initial forever #10 mclk_i = ~mclk_i;
    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    function automatic logic above(logic [11:0] m, logic [11:0] l,
                                   int p);
        return int'(m) > int'(l) * p / PCT_DIV;
    endfunction
    task automatic chk(string n, logic [11:0] e, logic [11:0] s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic check_all();
        logic v = prof.sel_ena && req && idx < NS;
        logic ok = mon >= VALID_LO && mon <= VALID_HI;
        chk("sel_oe", v ? 12'(1 << idx) : 12'h000, 12'(sel_oe));
        chk("sel_n", 12'h000, 12'(sel_n));
        if (v && !dsc) begin
            chk("ovp", 12'(above(mon, lvl[idx], OVP_PCT)), 12'(overvoltage_protect));
            chk("fault_oe", 12'(above(mon, lvl[idx], OVP_PCT)), 12'(flt_oe));
        end
        if (v && dsc) chk("dsch", 12'(above(mon, lvl[idx], DSCHG_PCT)), 12'(dsch));
        if (!dsc) chk("dsch_idle", 12'h000, 12'(dsch));
        chk("fault_n", 12'h000, 12'(flt_n));
        chk("bpres", 12'(prof.bpres_ena && stat.ufp && (ok || stat.transition)), 12'(bpres));
        chk("rid", 12'(!(pin || stat.micro_a)), 12'(rid));
        chk("chg", 12'(prof.chg_ena && !stat.contract && ok), 12'(chg));
    endtask
    // drop the discharge request first so each step starts clean
    task automatic step(logic [11:0] m, logic d);
        @(negedge mclk_i) dsc = 1'b0;
        repeat (2) @(negedge mclk_i);
        fval = m;
        dsc = d;
        repeat (8) @(negedge mclk_i);
        check_all();
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        int t;
        int n;
        logic [11:0] cor [6];
        void'($urandom(32'h32FA5E7F));
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i) rstn_i = 1'b1;
        t = int'(lvl[1]) * OVP_PCT / PCT_DIV;
        cor = '{12'(t), 12'(t + 1), VALID_LO - 12'h001, VALID_LO,
                VALID_HI, VALID_HI + 12'h001};
        prof = '1;
        stat = 4'h8;
        req = 1'b1;
        idx = 2'h1;
        foreach (cor[i]) for (int d = 0; d < 2; d++) step(cor[i], 1'(d));
        $display("test corners done");
        repeat (300) begin
            {idx, req, prof, stat, pin} = 11'($urandom);
            step(12'($urandom_range(0, 2100)), 1'($urandom));
        end
        $display("test random done");
        // live drop from the middle level to the lowest with the fet
        @(negedge mclk_i);
        frc = 1'b0;
        prof = '1;
        stat = 4'hB;
        pin = 1'b0;
        req = 1'b1;
        idx = 2'h1;
        dsc = 1'b0;
        repeat (300) @(negedge mclk_i);
        idx = 2'h0;
        dsc = 1'b1;
        n = 0;
        while (dsch !== 1'b1 && n < 20) begin
            @(negedge mclk_i);
            n++;
        end
        chk("dsch_rise", 12'h001, 12'(dsch));
        while (dsch !== 1'b0 && n < 200) begin
            chk("bpres_hold", 12'h001, 12'(bpres));
            @(negedge mclk_i);
            n++;
        end
        t = int'(lvl[0]) * DSCHG_PCT / PCT_DIV;
        chk("dsch_stop", 12'h001, 12'(int'(mon) <= t && int'(mon) > t - 80));
        check_all();
        $display("test transition done");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        $display("ERROR watchdog expected done seen hang");
        conclude();
    end
endmodule
